/* rtl/gpmc_defs.svh */
// constants for the gpio port mode control block
`ifndef GPMC_DEFS_SVH
`define GPMC_DEFS_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define GPMC_OFS_DATA    12'h000
`define GPMC_OFS_MODE_A  12'h010
`define GPMC_OFS_MODE_B  12'h020
`define GPMC_OFS_INTYPE  12'h030
`define GPMC_OFS_SLEW    12'h040
`define GPMC_OFS_CFG     12'h050
`define GPMC_OFS_DRV     12'h060
// ----------------------------------------------------------------
// layout and reset values
// ----------------------------------------------------------------
`define GPMC_NPORT       4
`define GPMC_NPIN        32
`define GPMC_PORT_MASK   32'h0101FFFF
`define GPMC_MODE_A_RST  8'hFF
`define GPMC_MODE_B_RST  8'h00
`define GPMC_LATCH_RST   8'hFF
`define GPMC_CFG_RPD     0
`define GPMC_CFG_PUEN    1
`define GPMC_DBG_DATA    0
`define GPMC_DBG_CLK     1
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define GPMC_DBG_HOLD_OSC 600
`define GPMC_BOOST_CLKS   2
`endif

/* rtl/gpmc_pkg.sv */
// types for the gpio port mode control block
package gpmc_pkg;
  typedef enum logic [1:0] {
    GPMC_QUASI = 2'b00,
    GPMC_PUSH  = 2'b01,
    GPMC_INPUT = 2'b10,
    GPMC_OPEN  = 2'b11
  } gpmc_mode_e;
  typedef enum logic [0:0] {
    GPMC_DBG_HOLD = 1'b0,
    GPMC_DBG_DONE = 1'b1
  } gpmc_dbg_e;
endpackage : gpmc_pkg

/* rtl/gpmc_top.sv */
// gpio ports with mode control, slew/input type and apb registers
`timescale 1ns/10ps
`include "gpmc_defs.svh"
module gpmc_top (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // slow oscillator sampled as a level
  input  wire logic        slow_internal_osc,
  // pins, 8 bits per port, port n at bits 8n+7..8n
  input  wire logic [31:0] pin_in,
  output logic      [31:0] pin_pull_down,
  output logic      [31:0] pin_strong_up,
  output logic      [31:0] pin_weak_up,
  output logic      [31:0] pin_very_weak_up,
  output logic      [31:0] pin_schmitt,
  output logic      [31:0] pin_fast_slew,
  // dual-use reset pin
  output logic             dual_pin_reset_mode,
  output logic             dual_pin_pullup
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // port 2 and 3 hold a single pin (bit 0); the mask trims the rest
  logic [31:0] port_data_reg;
  logic [31:0] port_mode_sel_a;
  logic [31:0] port_mode_sel_b;
  logic [31:0] port_input_type_sel;
  logic [31:0] port_slew_sel;
  logic        reset_pin_disable_cfg;
  logic        dual_pin_pullup_en;
  logic [31:0] next_port_data_reg;
  logic [31:0] next_port_mode_sel_a;
  logic [31:0] next_port_mode_sel_b;
  logic [31:0] next_port_input_type_sel;
  logic [31:0] next_port_slew_sel;
  logic        next_reset_pin_disable_cfg;
  logic        next_dual_pin_pullup_en;
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic        wr_en;
  logic        rd_en;
  logic [31:0] wmask;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // byte strobe to bit mask, one bit per port byte
  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : strb_mask

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [31:0] m);
    return ((old_v & ~m) | (new_v & m)) & `GPMC_PORT_MASK;
  endfunction : merge

  // one decode for the write error, so it cannot drift from the map
  function automatic logic mapped(input logic [11:0] a);
    return (a == `GPMC_OFS_DATA)   || (a == `GPMC_OFS_MODE_A) ||
           (a == `GPMC_OFS_MODE_B) || (a == `GPMC_OFS_INTYPE) ||
           (a == `GPMC_OFS_SLEW)   || (a == `GPMC_OFS_CFG)    ||
           (a == `GPMC_OFS_DRV);
  endfunction : mapped

  assign wr_en = psel & penable & pwrite & pready;
  assign rd_en = psel & ~penable & ~pwrite;
  assign wmask = strb_mask(pstrb);

  logic [31:0] sensed;
  logic [31:0] boost;
  gpmc_pkg::gpmc_dbg_e dbg_state;

  // ----------------------------------------------------------------
  // register next values
  // ----------------------------------------------------------------
  // write lands in access; read data is caught in setup
  always_comb begin
    next_port_data_reg         = port_data_reg;
    next_port_mode_sel_a       = port_mode_sel_a;
    next_port_mode_sel_b       = port_mode_sel_b;
    next_port_input_type_sel   = port_input_type_sel;
    next_port_slew_sel         = port_slew_sel;
    next_reset_pin_disable_cfg = reset_pin_disable_cfg;
    next_dual_pin_pullup_en    = dual_pin_pullup_en;
    next_prdata                = prdata;
    next_pslverr               = 1'b0;
    if (wr_en) begin
      // byte strobes let software touch one port without disturbing others
      if (paddr == `GPMC_OFS_DATA) begin
        next_port_data_reg = merge(port_data_reg, pwdata, wmask);
      end else if (paddr == `GPMC_OFS_MODE_A) begin
        next_port_mode_sel_a = merge(port_mode_sel_a, pwdata, wmask);
      end else if (paddr == `GPMC_OFS_MODE_B) begin
        next_port_mode_sel_b = merge(port_mode_sel_b, pwdata, wmask);
      end else if (paddr == `GPMC_OFS_INTYPE) begin
        next_port_input_type_sel = merge(port_input_type_sel, pwdata, wmask);
      end else if (paddr == `GPMC_OFS_SLEW) begin
        next_port_slew_sel = merge(port_slew_sel, pwdata, wmask);
      end else if (paddr == `GPMC_OFS_CFG) begin
        if (pstrb[0]) begin
          next_reset_pin_disable_cfg = pwdata[`GPMC_CFG_RPD];
          next_dual_pin_pullup_en    = pwdata[`GPMC_CFG_PUEN];
        end
      end
    end
    // decided in setup so the error rides out together with pready
    if (psel & ~penable & pwrite & ~mapped(paddr)) begin
      next_pslverr = 1'b1;
    end
    if (rd_en) begin
      if (paddr == `GPMC_OFS_DATA) begin
        next_prdata = sensed;
      end else if (paddr == `GPMC_OFS_MODE_A) begin
        next_prdata = port_mode_sel_a;
      end else if (paddr == `GPMC_OFS_MODE_B) begin
        next_prdata = port_mode_sel_b;
      end else if (paddr == `GPMC_OFS_INTYPE) begin
        next_prdata = port_input_type_sel;
      end else if (paddr == `GPMC_OFS_SLEW) begin
        next_prdata = port_slew_sel;
      end else if (paddr == `GPMC_OFS_CFG) begin
        next_prdata = {30'h00000000, dual_pin_pullup_en, reset_pin_disable_cfg};
      end else if (paddr == `GPMC_OFS_DRV) begin
        // latch view for read-modify-write, never the pin level
        next_prdata = port_data_reg;
      end else begin
        next_prdata = 32'h00000000;
      end
    end
  end

  // ----------------------------------------------------------------
  // apb handshake and register state
  // ----------------------------------------------------------------
  // two-phase access: setup latches read data, access completes at once
  logic next_pready;
  assign next_pready = psel & ~penable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_data_reg         <= `GPMC_PORT_MASK;
      port_mode_sel_a       <= `GPMC_PORT_MASK;
      port_mode_sel_b       <= 32'h00000000;
      port_input_type_sel   <= 32'h00000000;
      port_slew_sel         <= 32'h00000000;
      reset_pin_disable_cfg <= 1'b0;
      dual_pin_pullup_en    <= 1'b0;
      prdata                <= 32'h00000000;
      pready                <= 1'b0;
      pslverr               <= 1'b0;
    end else begin
      port_data_reg         <= next_port_data_reg;
      port_mode_sel_a       <= next_port_mode_sel_a;
      port_mode_sel_b       <= next_port_mode_sel_b;
      port_input_type_sel   <= next_port_input_type_sel;
      port_slew_sel         <= next_port_slew_sel;
      reset_pin_disable_cfg <= next_reset_pin_disable_cfg;
      dual_pin_pullup_en    <= next_dual_pin_pullup_en;
      prdata                <= next_prdata;
      pready                <= next_pready;
      pslverr               <= next_pslverr & next_pready;
    end
  end

  // ----------------------------------------------------------------
  // debug pin hold after reset, counted on slow oscillator edges
  // ----------------------------------------------------------------
  logic [1:0]  osc_sync;
  logic        osc_prev;
  logic [9:0]  osc_cnt;
  logic [1:0]  next_osc_sync;
  logic        next_osc_prev;
  logic [9:0]  next_osc_cnt;
  gpmc_pkg::gpmc_dbg_e next_dbg_state;

  always_comb begin
    next_osc_sync  = {osc_sync[0], slow_internal_osc};
    next_osc_prev  = osc_sync[1];
    next_osc_cnt   = osc_cnt;
    next_dbg_state = dbg_state;
    case (dbg_state)
      gpmc_pkg::GPMC_DBG_HOLD: begin
        if (osc_sync[1] & ~osc_prev) begin
          next_osc_cnt = osc_cnt + 10'h001;
          if (osc_cnt == 10'(`GPMC_DBG_HOLD_OSC - 1)) begin
            next_dbg_state = gpmc_pkg::GPMC_DBG_DONE;
          end
        end
      end
      default: next_dbg_state = gpmc_pkg::GPMC_DBG_DONE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_sync  <= 2'h0;
      osc_prev  <= 1'b0;
      osc_cnt   <= 10'h000;
      dbg_state <= gpmc_pkg::GPMC_DBG_HOLD;
    end else begin
      osc_sync  <= next_osc_sync;
      osc_prev  <= next_osc_prev;
      osc_cnt   <= next_osc_cnt;
      dbg_state <= next_dbg_state;
    end
  end

  // ----------------------------------------------------------------
  // per-pin drive logic
  // ----------------------------------------------------------------
  logic [31:0] latch_prev;
  logic [1:0]  boost_cnt [32];
  logic [1:0]  next_boost_cnt [32];
  logic [31:0] next_pull_down;
  logic [31:0] next_strong_up;
  logic [31:0] next_weak_up;
  logic [31:0] next_very_weak_up;

  // sensed levels: dual pin reads zero while it is the reset input
  always_comb begin
    sensed = pin_in & `GPMC_PORT_MASK;
    if (!reset_pin_disable_cfg) begin
      sensed[16] = 1'b0;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `GPMC_NPIN; gi++) begin : g_pin
      gpmc_pkg::gpmc_mode_e md;
      logic lat;
      always_comb begin
        md  = gpmc_pkg::gpmc_mode_e'({port_mode_sel_a[gi],
                                      port_mode_sel_b[gi]});
        lat = port_data_reg[gi];
        if ((gi == `GPMC_DBG_DATA || gi == `GPMC_DBG_CLK) &&
            dbg_state == gpmc_pkg::GPMC_DBG_HOLD) begin
          md  = gpmc_pkg::GPMC_QUASI;
          lat = 1'b1;
        end
        if (gi == 16) begin
          md = gpmc_pkg::GPMC_INPUT;
        end
        next_boost_cnt[gi] = (boost_cnt[gi] != 2'h0) ?
                             boost_cnt[gi] - 2'h1 : 2'h0;
        // a new rising edge mid-boost restarts the two-clock window
        if (md == gpmc_pkg::GPMC_QUASI && lat && !latch_prev[gi]) begin
          next_boost_cnt[gi] = 2'(`GPMC_BOOST_CLKS);
        end
        boost[gi] = (next_boost_cnt[gi] != 2'h0);
        next_pull_down[gi]    = 1'b0;
        next_strong_up[gi]    = 1'b0;
        next_weak_up[gi]      = 1'b0;
        next_very_weak_up[gi] = 1'b0;
        case (md)
          gpmc_pkg::GPMC_QUASI: begin
            next_pull_down[gi]    = ~lat;
            next_very_weak_up[gi] = lat;
            next_weak_up[gi]      = lat & pin_in[gi];
            next_strong_up[gi]    = lat & boost[gi];
          end
          gpmc_pkg::GPMC_PUSH: begin
            next_pull_down[gi] = ~lat;
            next_strong_up[gi] = lat;
          end
          gpmc_pkg::GPMC_OPEN: begin
            next_pull_down[gi] = ~lat;
          end
          default: begin
          end
        endcase
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // drive outputs
  // ----------------------------------------------------------------
  // registered so no pin enable can glitch on a decode change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_prev          <= `GPMC_PORT_MASK;
      pin_pull_down       <= 32'h00000000;
      pin_strong_up       <= 32'h00000000;
      pin_weak_up         <= 32'h00000000;
      pin_very_weak_up    <= 32'h00000000;
      pin_schmitt         <= 32'h00000000;
      pin_fast_slew       <= 32'h00000000;
      dual_pin_reset_mode <= 1'b1;
      dual_pin_pullup     <= 1'b1;
      for (int i = 0; i < `GPMC_NPIN; i++) begin
        boost_cnt[i] <= 2'h0;
      end
    end else begin
      latch_prev       <= port_data_reg;
      pin_pull_down    <= next_pull_down & `GPMC_PORT_MASK;
      pin_strong_up    <= next_strong_up & `GPMC_PORT_MASK;
      pin_weak_up      <= next_weak_up & `GPMC_PORT_MASK;
      pin_very_weak_up <= next_very_weak_up & `GPMC_PORT_MASK;
      pin_schmitt      <= (port_input_type_sel |
                          {15'h0000, 1'b1, 16'h0000}) & `GPMC_PORT_MASK;
      pin_fast_slew    <= port_slew_sel;
      dual_pin_reset_mode <= ~reset_pin_disable_cfg;
      dual_pin_pullup  <= ~reset_pin_disable_cfg | dual_pin_pullup_en;
      for (int i = 0; i < `GPMC_NPIN; i++) begin
        boost_cnt[i] <= next_boost_cnt[i];
      end
    end
  end
endmodule : gpmc_top

/* testbench/gpio_port_mode_control_tb.sv */
// self-checking bench for the gpio port mode control block
`timescale 1ns/10ps
`include "gpmc_defs.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  err_total++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module gpio_port_mode_control_tb;
  logic        pclk = 1'b0, presetn = 1'b0, osc = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [3:0]  pstrb = 4'hF;
  logic [31:0] pwdata = 32'h0, ext_en = 32'h0, ext_val = 32'h0;
  logic [31:0] prdata, pin_in, pd, su, wu, vu, sch, fs, rd;
  logic        pready, pslverr, drm, dpu, er;
  int          err_total = 0, num_checks = 0, n;

  gpmc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slow_internal_osc(osc), .pin_in(pin_in), .pin_pull_down(pd),
    .pin_strong_up(su), .pin_weak_up(wu), .pin_very_weak_up(vu),
    .pin_schmitt(sch), .pin_fast_slew(fs), .dual_pin_reset_mode(drm),
    .dual_pin_pullup(dpu));
  gpmc_pin_model u_pins (.pclk(pclk), .pull_down(pd), .any_up(su | wu | vu),
    .dual_pullup(dpu), .ext_en(ext_en), .ext_val(ext_val), .level(pin_in));

  always #5 pclk = ~pclk;

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no own limit: a slave that never answers is the watchdog's case
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task settle;
    repeat (5) @(posedge pclk);
  endtask : settle

  task t_reset;
    settle;
    `CHK("dbg_up", 2'b11, vu[1:0])
    `CHK("pd", 32'h0, pd)
    `CHK("slew", 32'h0, fs)
    `CHK("rst_mode", 1'b1, drm)
    $display("test reset done");
  endtask : t_reset

  task t_debug;
    repeat (600) begin
      repeat (3) @(posedge pclk);
      osc <= 1'b1;
      repeat (3) @(posedge pclk);
      osc <= 1'b0;
    end
    settle;
    `CHK("idle", 32'h0, pd | su | wu | vu)
    $display("test debug release done");
  endtask : t_debug

  task t_quasi;
    apb(1'b1, `GPMC_OFS_MODE_A, 32'h0);
    apb(1'b1, `GPMC_OFS_DATA, 32'h0);
    settle;
    `CHK("pd", 8'hFF, pd[7:0])
    `CHK("vu", 8'h00, vu[7:0])
    apb(1'b1, `GPMC_OFS_DATA, 32'hFFFFFFFF);
    n = 0;
    repeat (8) begin
      @(posedge pclk);
      if (su[2] === 1'b1) n++;
    end
    `CHK("boost", 2, n)
    `CHK("vu", 8'hFF, vu[7:0])
    ext_en <= 32'h8;
    settle;
    `CHK("wu", 8'hF7, wu[7:0])
    apb(1'b0, `GPMC_OFS_DATA, 32'h0);
    `CHK("pins", 8'hF7, rd[7:0])
    apb(1'b0, `GPMC_OFS_DRV, 32'h0);
    `CHK("latch", 8'hFF, rd[7:0])
    ext_en <= 32'h0;
    $display("test quasi done");
  endtask : t_quasi

  task t_modes;
    apb(1'b1, `GPMC_OFS_MODE_A, 32'h0C);
    apb(1'b1, `GPMC_OFS_MODE_B, 32'h0A);
    apb(1'b1, `GPMC_OFS_DATA, 32'h0);
    settle;
    `CHK("pd", 4'hB, pd[3:0])
    apb(1'b1, `GPMC_OFS_DATA, 32'hFF);
    repeat (20) @(posedge pclk);
    `CHK("su", 4'h2, su[3:0])
    `CHK("vu", 4'h1, vu[3:0])
    `CHK("pd", 4'h0, pd[3:0])
    $display("test modes done");
  endtask : t_modes

  task t_misc;
    apb(1'b1, `GPMC_OFS_INTYPE, 32'hA5);
    apb(1'b1, `GPMC_OFS_SLEW, 32'h5A);
    settle;
    `CHK("schmitt", 8'hA5, sch[7:0])
    `CHK("slew", 8'h5A, fs[7:0])
    apb(1'b1, 12'h070, 32'h0);
    `CHK("err", 1'b1, er)
    apb(1'b0, 12'h070, 32'h0);
    `CHK("rd", 32'h0, rd)
    $display("test input and bus done");
  endtask : t_misc

  task t_dual;
    ext_en <= 32'h10000;
    ext_val <= 32'h10000;
    apb(1'b0, `GPMC_OFS_DATA, 32'h0);
    `CHK("p16", 1'b0, rd[16])
    apb(1'b1, `GPMC_OFS_CFG, 32'h1);
    settle;
    `CHK("mode", 2'b00, {drm, dpu})
    apb(1'b1, `GPMC_OFS_CFG, 32'h3);
    apb(1'b0, `GPMC_OFS_DATA, 32'h0);
    settle;
    `CHK("p16", 1'b1, rd[16])
    `CHK("pu", 2'b11, {dpu, sch[16]})
    $display("test dual pin done");
  endtask : t_dual

  task final_report;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_debug;
    t_quasi;
    t_modes;
    t_misc;
    t_dual;
    final_report;
  end

  initial begin
    repeat (30000) @(posedge pclk);
    err_total++;
    final_report;
  end
endmodule : gpio_port_mode_control_tb

/* testbench/gpmc_pin_model.sv */
// devices and pull resistors seen by the gpio pins
`timescale 1ns/10ps
module gpmc_pin_model (
  // clock
  input  wire logic        pclk,
  // block drive enables
  input  wire logic [31:0] pull_down,
  input  wire logic [31:0] any_up,
  input  wire logic        dual_pullup,
  // external drivers
  input  wire logic [31:0] ext_en,
  input  wire logic [31:0] ext_val,
  // resolved pin levels
  output logic      [31:0] level
);
  logic flt = 1'b0;
  // undriven pins toggle so a stale level cannot pass for a pull
  always @(posedge pclk) flt <= ~flt;
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (pull_down[i])
        level[i] = 1'b0;
      else if (ext_en[i])
        level[i] = ext_val[i];
      else if (any_up[i] || (i == 16 && dual_pullup))
        level[i] = 1'b1;
      else
        level[i] = flt;
    end
  end
endmodule : gpmc_pin_model

/* testbench/gpmc_top_monitor.sv */
// checker on the apb and pin-drive ports of the gpio block
`timescale 1ns/10ps
`include "gpmc_defs.svh"
module gpmc_top_monitor (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pins
  input wire logic [31:0] pin_pull_down,
  input wire logic [31:0] pin_strong_up,
  input wire logic [31:0] pin_weak_up,
  input wire logic [31:0] pin_very_weak_up,
  input wire logic        dual_pin_reset_mode,
  input wire logic        dual_pin_pullup
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic [31:0] drv = pin_pull_down | pin_strong_up | pin_weak_up
                          | pin_very_weak_up;
  wire logic        rd_ack = pready && !pwrite;

  setup_answer_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("access phase not answered in one cycle");
  error_unmapped_a: assert property (pready && pwrite && paddr > 12'h060
    |-> pslverr) else $error("unmapped write without error");
  no_error_mapped_a: assert property (pready && paddr <= 12'h060
    |-> !pslverr) else $error("error on a mapped register");
  read_unmapped_a: assert property (rd_ack && paddr > 12'h060
    |-> prdata == 32'h0) else $error("unmapped read not zero");
  dual_reads_zero_a: assert property (rd_ack && paddr == 12'h000
    && dual_pin_reset_mode |-> !prdata[16]) else $error("reset pin read");
  no_fight_a: assert property ((pin_pull_down & (pin_strong_up
    | pin_very_weak_up)) == 32'h0) else $error("pull-down fights pull-up");
  absent_pins_a: assert property ((drv & ~`GPMC_PORT_MASK)
    == 32'h0) else $error("drive on an absent pin");
  dual_input_a: assert property (!pin_pull_down[16]
    && !pin_strong_up[16]) else $error("dual-use pin driven");
  reset_pullup_a: assert property (dual_pin_reset_mode
    |-> dual_pin_pullup) else $error("reset pin pull-up off");
endmodule : gpmc_top_monitor

bind gpmc_top gpmc_top_monitor u_mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pin_pull_down(pin_pull_down), .pin_strong_up(pin_strong_up),
  .pin_weak_up(pin_weak_up), .pin_very_weak_up(pin_very_weak_up),
  .dual_pin_reset_mode(dual_pin_reset_mode),
  .dual_pin_pullup(dual_pin_pullup));
